// >>> cew_expand.sv
`timescale 1ns/1ps
`default_nettype none

// Turns each selector bit into a full plane colour: every plane gets its colour bit where the
// selector is 1 and its background bit where it is 0.
module cew_expand #(
  parameter int NUM_PLANES = 4,
  parameter int PIX = 8
) (
  input wire logic [PIX-1:0] selector,
  input wire logic [PIX-1:0] fgColor,
  input wire logic [PIX-1:0] bgColor,
  output logic [NUM_PLANES*PIX-1:0] expanded
);

  if (NUM_PLANES < 1 || NUM_PLANES > PIX) begin : g_bad_planes
    $error("cew_expand: plane count must lie between 1 and the colour width");
  end

  for (genvar p = 0; p < NUM_PLANES; p++) begin : g_plane
    for (genvar i = 0; i < PIX; i++) begin : g_pix
      // Each pixel chooses on its own, so one write paints text and background at once.
      assign expanded[p*PIX+i] = selector[i] ? fgColor[p] : bgColor[p];
    end
  end

endmodule : cew_expand

`default_nettype wire

// >>> cew_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host side of the port pair; released address and data lines show the inverse of their last value, strobes drop to 0.
module cew_host_model (
  input wire logic clk,
  output logic [15:0] ioAddr,
  output logic ioWr,
  output logic ioRd,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData
);
  initial begin
    ioAddr = 16'h0000;
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioWrData = 8'h00;
  end

  task automatic port(input logic [15:0] a, input logic [7:0] d, input logic rd);
    @(negedge clk);
    ioAddr = a;
    ioWrData = d;
    ioWr = !rd;
    ioRd = rd;
    @(negedge clk);
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioAddr = ~a;
    ioWrData = ~d;
  endtask : port

  task automatic putReg(input logic [7:0] idx, input logic [7:0] val);
    port(cew_pkg::SEQ_INDEX_PORT, idx, 1'b0);
    port(cew_pkg::SEQ_DATA_PORT, val, 1'b0);
  endtask : putReg

  task automatic getReg(input logic [7:0] idx, output logic [7:0] val);
    port(cew_pkg::SEQ_INDEX_PORT, idx, 1'b0);
    port(cew_pkg::SEQ_DATA_PORT, 8'h00, 1'b1);
    @(negedge clk);
    val = ioRdData;
  endtask : getReg
endmodule : cew_host_model

`default_nettype wire

// >>> cew_pkg.sv
package cew_pkg;

  // Host port addresses of the sequencer index/data pair.
  localparam logic [15:0] SEQ_INDEX_PORT = 16'h03C4;
  localparam logic [15:0] SEQ_DATA_PORT = 16'h03C5;

  // Extension register indices.
  localparam logic [7:0] IDX_PATTERN = 8'hF5;
  localparam logic [7:0] IDX_FG_COLOR = 8'hFA;
  localparam logic [7:0] IDX_BG_COLOR = 8'hFB;
  localparam logic [7:0] IDX_EXP_CTRL = 8'hFE;

  // Values after reset.
  localparam logic [7:0] RST_INDEX = 8'h00;
  localparam logic [7:0] RST_PATTERN = 8'h00;
  localparam logic [7:0] RST_FG_COLOR = 8'h00;
  localparam logic [7:0] RST_BG_COLOR = 8'h00;
  localparam logic [7:0] RST_EXP_CTRL = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;

  // Field positions in the expansion control register.
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_MODE_MSB = 3;
  localparam int CTRL_SEL_BIT = 1;

  // Mode field codes; 2'b10 and 2'b11 are reserved.
  localparam logic [1:0] MODE_STANDARD = 2'h0;
  localparam logic [1:0] MODE_EXPAND = 2'h1;

  // Write mode codes.
  localparam logic [1:0] WMODE_0 = 2'h0;
  localparam logic [1:0] WMODE_1 = 2'h1;
  localparam logic [1:0] WMODE_2 = 2'h2;
  localparam logic [1:0] WMODE_3 = 2'h3;

  // Cycles from an accepted memory write to its result on the outputs.
  localparam int WRITE_LATENCY = 1;

endpackage : cew_pkg

// >>> cew_write_path.sv
`timescale 1ns/1ps
`default_nettype none

module cew_write_path #(
  parameter int NUM_PLANES = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [15:0] ioAddr,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic memWr,
  input wire logic [7:0] cpuData,
  input wire logic [2:0] rotateCount,
  input wire logic [1:0] writeMode,
  input wire logic [NUM_PLANES-1:0] setReset,
  input wire logic [NUM_PLANES-1:0] enableSetReset,
  input wire logic [7:0] bitMask,
  input wire logic [NUM_PLANES-1:0] mapMask,
  input wire logic maskedWriteEn,
  input wire logic [7:0] maskedWriteMask,
  input wire logic [NUM_PLANES*8-1:0] latchData,
  output logic memWrOut,
  output logic [NUM_PLANES*8-1:0] planeData,
  output logic [NUM_PLANES-1:0] planeEnable,
  output logic [7:0] bitEnable
);

  if (NUM_PLANES < 1 || NUM_PLANES > 8) begin : g_bad_planes
    $error("cew_write_path: plane count must lie between 1 and 8");
  end

  function automatic logic [7:0] rotr(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] w;
    w = {d, d} >> n;
    return w[7:0];
  endfunction : rotr

  logic [7:0] index_reg;
  logic [7:0] pattern_reg;
  logic [7:0] fgColor_reg;
  logic [7:0] bgColor_reg;
  logic [7:0] expCtrl_reg;
  logic [7:0] ioRdData_reg;
  logic memWrOut_reg;
  logic [NUM_PLANES*8-1:0] planeData_reg;
  logic [NUM_PLANES*8-1:0] planeData_next;
  logic [NUM_PLANES-1:0] planeEnable_reg;
  logic [7:0] bitEnable_reg;
  logic [7:0] bitEnable_next;

  logic idxWrite;
  logic dataWrite;
  logic dataRead;
  logic [1:0] modeField;
  logic [7:0] rotByte;
  logic [7:0] selByte;
  logic [7:0] effMask;
  logic [NUM_PLANES*8-1:0] expanded;
  logic [NUM_PLANES*8-1:0] srcSetReset;
  logic [NUM_PLANES*8-1:0] srcData;

  assign idxWrite = ioWr && (ioAddr == cew_pkg::SEQ_INDEX_PORT);
  assign dataWrite = ioWr && (ioAddr == cew_pkg::SEQ_DATA_PORT);
  assign dataRead = ioRd && (ioAddr == cew_pkg::SEQ_DATA_PORT);

  // Index register of the port pair.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      index_reg <= cew_pkg::RST_INDEX;
    end else if (idxWrite) begin
      index_reg <= ioWrData;
    end
  end

  // Extension registers; writes land through the data port at the latched index.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pattern_reg <= cew_pkg::RST_PATTERN;
      fgColor_reg <= cew_pkg::RST_FG_COLOR;
      bgColor_reg <= cew_pkg::RST_BG_COLOR;
      expCtrl_reg <= cew_pkg::RST_EXP_CTRL;
    end else if (dataWrite) begin
      unique case (index_reg)
        cew_pkg::IDX_PATTERN: pattern_reg <= ioWrData;
        cew_pkg::IDX_FG_COLOR: fgColor_reg <= ioWrData;
        cew_pkg::IDX_BG_COLOR: bgColor_reg <= ioWrData;
        cew_pkg::IDX_EXP_CTRL: expCtrl_reg <= ioWrData;
        default: ;
      endcase
    end
  end

  // Read-back; the index port returns the index, unknown indices read as zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ioRdData_reg <= cew_pkg::RST_READ_DATA;
    end else if (ioRd && ioAddr == cew_pkg::SEQ_INDEX_PORT) begin
      ioRdData_reg <= index_reg;
    end else if (dataRead) begin
      unique case (index_reg)
        cew_pkg::IDX_PATTERN: ioRdData_reg <= pattern_reg;
        cew_pkg::IDX_FG_COLOR: ioRdData_reg <= fgColor_reg;
        cew_pkg::IDX_BG_COLOR: ioRdData_reg <= bgColor_reg;
        cew_pkg::IDX_EXP_CTRL: ioRdData_reg <= expCtrl_reg;
        default: ioRdData_reg <= cew_pkg::RST_READ_DATA;
      endcase
    end
  end

  assign modeField = expCtrl_reg[cew_pkg::CTRL_MODE_MSB:cew_pkg::CTRL_MODE_LSB];
  assign rotByte = rotr(cpuData, rotateCount);
  assign selByte = expCtrl_reg[cew_pkg::CTRL_SEL_BIT] ? rotByte : pattern_reg;
  assign effMask = (writeMode == cew_pkg::WMODE_3) ? (rotByte & bitMask) : bitMask;

  cew_expand #(
    .NUM_PLANES(NUM_PLANES),
    .PIX(8)
  ) u_expand (
    .selector(selByte),
    .fgColor(fgColor_reg),
    .bgColor(bgColor_reg),
    .expanded(expanded)
  );

  // Set/reset stage per plane, then the CPU-side source select.
  always_comb begin
    for (int p = 0; p < NUM_PLANES; p++) begin
      unique case (writeMode)
        cew_pkg::WMODE_2: srcSetReset[p*8 +: 8] = {8{cpuData[p]}};
        cew_pkg::WMODE_3: srcSetReset[p*8 +: 8] = {8{setReset[p]}};
        default: srcSetReset[p*8 +: 8] = enableSetReset[p] ? {8{setReset[p]}} : rotByte;
      endcase
    end
  end

  // Reserved codes fall back to set/reset so a stray setting cannot scramble memory.
  assign srcData = (modeField == cew_pkg::MODE_EXPAND) ? expanded : srcSetReset;

  always_comb begin
    for (int p = 0; p < NUM_PLANES; p++) begin
      if (writeMode == cew_pkg::WMODE_1) begin
        planeData_next[p*8 +: 8] = latchData[p*8 +: 8];
      end else begin
        planeData_next[p*8 +: 8] = (srcData[p*8 +: 8] & effMask)
                                 | (latchData[p*8 +: 8] & ~effMask);
      end
    end
  end

  assign bitEnable_next = maskedWriteEn ? maskedWriteMask : 8'hFF;

  // One registered write strobe carries every plane, so colours land in a single cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      memWrOut_reg <= 1'h0;
      planeData_reg <= '0;
      planeEnable_reg <= '0;
      bitEnable_reg <= 8'h00;
    end else begin
      memWrOut_reg <= memWr;
      if (memWr) begin
        planeData_reg <= planeData_next;
        planeEnable_reg <= mapMask;
        bitEnable_reg <= bitEnable_next;
      end
    end
  end

  assign ioRdData = ioRdData_reg;
  assign memWrOut = memWrOut_reg;
  assign planeData = planeData_reg;
  assign planeEnable = planeEnable_reg;
  assign bitEnable = bitEnable_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_index_fg;
    idxWrite && ioWrData == cew_pkg::IDX_FG_COLOR;
  endsequence
  sequence s_index_bg;
    idxWrite && ioWrData == cew_pkg::IDX_BG_COLOR;
  endsequence

  // The index persists, so the data access may come any number of cycles after it.
  a_fg_index_held: assert property (s_index_fg |=> index_reg == cew_pkg::IDX_FG_COLOR)
    else $error("foreground index not latched by the index port");
  a_bg_index_held: assert property (s_index_bg |=> index_reg == cew_pkg::IDX_BG_COLOR)
    else $error("background index not latched by the index port");
  a_fg_port_write: assert property (dataWrite && index_reg == cew_pkg::IDX_FG_COLOR
      |=> fgColor_reg == $past(ioWrData))
    else $error("foreground colour not written through the port pair");
  a_bg_port_write: assert property (dataWrite && index_reg == cew_pkg::IDX_BG_COLOR
      |=> bgColor_reg == $past(ioWrData) && fgColor_reg == $past(fgColor_reg))
    else $error("background colour write wrong or touched foreground");
  a_ctrl_read_back: assert property (dataRead && index_reg == cew_pkg::IDX_EXP_CTRL
      |=> ioRdData == $past(expCtrl_reg))
    else $error("control register read-back mismatch");
  a_expand_pixel: assert property (memWr && modeField == cew_pkg::MODE_EXPAND
      && writeMode == cew_pkg::WMODE_0 && bitMask[0]
      |=> planeData[0] == ($past(selByte[0]) ? $past(fgColor_reg[0]) : $past(bgColor_reg[0])))
    else $error("expanded pixel has the wrong colour");
  a_sel_cpu_byte: assert property (memWr && expCtrl_reg[cew_pkg::CTRL_SEL_BIT]
      && modeField == cew_pkg::MODE_EXPAND && writeMode == cew_pkg::WMODE_0 && bitMask[7]
      |=> planeData[7] == ($past(rotByte[7]) ? $past(fgColor_reg[0]) : $past(bgColor_reg[0])))
    else $error("selector did not use the rotated CPU byte");
  a_std_route: assert property (memWr && modeField != cew_pkg::MODE_EXPAND
      && writeMode == cew_pkg::WMODE_0 && bitMask == 8'hFF
      |=> planeData[7:0] == ($past(enableSetReset[0]) ? {8{$past(setReset[0])}}
      : $past(rotByte)))
    else $error("standard or reserved mode did not route set/reset");
  a_rotate_feed: assert property (memWr && rotateCount == 3'h3 && writeMode == cew_pkg::WMODE_0
      && !enableSetReset[0] && modeField == cew_pkg::MODE_STANDARD
      |=> ((planeData[7:0] ^ {$past(cpuData[2:0]), $past(cpuData[7:3])}) & $past(bitMask))
      == 8'h00)
    else $error("CPU byte not rotated before the data path");
  a_bit_mask_mix: assert property (memWr && writeMode != cew_pkg::WMODE_3 && !bitMask[0]
      |=> planeData[0] == $past(latchData[0]))
    else $error("masked bit did not take the latch");
  a_wm3_and_mask: assert property (memWr && writeMode == cew_pkg::WMODE_3 && !rotByte[0]
      |=> planeData[0] == $past(latchData[0]))
    else $error("write mode 3 mask not ANDed with CPU byte");
  a_clip_mask: assert property (memWr && maskedWriteEn
      |=> memWrOut && bitEnable == $past(maskedWriteMask))
    else $error("masked-write clipping not applied");
  a_all_planes: assert property (memWr |=> memWrOut && planeEnable == $past(mapMask)
      ##1 !memWrOut || $past(memWr))
    else $error("write strobe or plane enables wrong");

endmodule : cew_write_path

`default_nettype wire

// >>> tb_color_expand_write_path.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin nErrors++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end

module tb_color_expand_write_path;
  logic clk, sysRst, ioWr, ioRd, memWr, memWrOut, maskedWriteEn;
  logic [15:0] ioAddr;
  logic [7:0] ioWrData, ioRdData, cpuData, bitMask, maskedWriteMask, bitEnable, rv;
  logic [7:0] pat, fg, bg, ctrl;
  logic [2:0] rotateCount;
  logic [1:0] writeMode;
  logic [3:0] setReset, enableSetReset, mapMask, planeEnable;
  logic [31:0] latchData, planeData;
  int nErrors = 0;
  int checkCount = 0;

  cew_host_model host (.clk(clk), .ioAddr(ioAddr), .ioWr(ioWr), .ioRd(ioRd),
    .ioWrData(ioWrData), .ioRdData(ioRdData));
  cew_write_path #(.NUM_PLANES(4)) uut (.clk(clk), .sys_rst(sysRst), .ioAddr(ioAddr),
    .ioWr(ioWr), .ioRd(ioRd), .ioWrData(ioWrData), .ioRdData(ioRdData), .memWr(memWr),
    .cpuData(cpuData), .rotateCount(rotateCount), .writeMode(writeMode),
    .setReset(setReset), .enableSetReset(enableSetReset), .bitMask(bitMask),
    .mapMask(mapMask), .maskedWriteEn(maskedWriteEn), .maskedWriteMask(maskedWriteMask),
    .latchData(latchData), .memWrOut(memWrOut), .planeData(planeData),
    .planeEnable(planeEnable), .bitEnable(bitEnable));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [31:0] expd(input logic [7:0] d);
    logic [7:0] r, s, m, src;
    logic [31:0] o;
    r = 8'({d, d} >> rotateCount);
    s = ctrl[1] ? r : pat;
    m = (writeMode == cew_pkg::WMODE_3) ? (r & bitMask) : bitMask;
    for (int p = 0; p < 4; p++) begin
      src = {8{setReset[p]}};
      if (writeMode == cew_pkg::WMODE_0) src = enableSetReset[p] ? src : r;
      if (writeMode == cew_pkg::WMODE_2) src = {8{d[p]}};
      if (ctrl[3:2] == 2'h1) src = (s & {8{fg[p]}}) | (~s & {8{bg[p]}});
      o[8*p+:8] = (src & m) | (latchData[8*p+:8] & ~m);
      if (writeMode == cew_pkg::WMODE_1) o[8*p+:8] = latchData[8*p+:8];
    end
    return o;
  endfunction : expd

  task automatic setRegs(input logic [7:0] p, f, b, c);
    pat = p;
    fg = f;
    bg = b;
    ctrl = c;
    host.putReg(cew_pkg::IDX_PATTERN, p);
    host.putReg(cew_pkg::IDX_FG_COLOR, f);
    host.putReg(cew_pkg::IDX_BG_COLOR, b);
    host.putReg(cew_pkg::IDX_EXP_CTRL, c);
  endtask : setRegs

  task automatic memWrite(input logic [7:0] d);
    @(negedge clk);
    memWr = 1'b1;
    cpuData = d;
    @(negedge clk);
    memWr = 1'b0;
    cpuData = ~d;
    `CHK(memWrOut, 1'b1)
    `CHK(planeData, expd(d))
    `CHK(planeEnable, mapMask)
    `CHK(bitEnable, maskedWriteEn ? maskedWriteMask : 8'hFF)
    @(negedge clk);
    `CHK(memWrOut, 1'b0)
  endtask : memWrite

  task automatic t_regs;
    logic [7:0] idx [4] = '{cew_pkg::IDX_PATTERN, cew_pkg::IDX_FG_COLOR,
      cew_pkg::IDX_BG_COLOR, cew_pkg::IDX_EXP_CTRL};
    `CHK(planeData, 32'h0000_0000)
    for (int i = 0; i < 4; i++) begin
      host.getReg(idx[i], rv);
      `CHK(rv, 8'h00)
      host.putReg(idx[i], 8'hA5 ^ 8'(i));
      host.getReg(idx[i], rv);
      `CHK(rv, 8'hA5 ^ 8'(i))
    end
    // An unmapped index must neither store nor answer.
    host.putReg(8'hF6, 8'h5A);
    host.getReg(8'hF6, rv);
    `CHK(rv, 8'h00)
  endtask : t_regs

  task automatic t_walk;
    setRegs(8'h00, 8'h0E, 8'h01, 8'h06);
    memWrite(8'hF0);
    `CHK(planeData, 32'hF0F0_F00F)
    fg = 8'h0B;
    host.putReg(cew_pkg::IDX_FG_COLOR, fg);
    memWrite(8'h3C);
  endtask : t_walk

  task automatic t_modes;
    rotateCount = 3'h3;
    setReset = 4'h5;
    enableSetReset = 4'h6;
    bitMask = 8'hF3;
    latchData = 32'h1234_5678;
    for (int c = 0; c < 8; c++) begin
      setRegs(8'h3C, 8'h09, 8'h06, 8'({c, 1'b0}));
      for (int w = 0; w < 4; w++) begin
        writeMode = 2'(w);
        memWrite(8'hB1);
      end
    end
  endtask : t_modes

  task automatic t_clip;
    writeMode = cew_pkg::WMODE_0;
    maskedWriteEn = 1'b1;
    maskedWriteMask = 8'h0F;
    mapMask = 4'h6;
    bitMask = 8'h5A;
    setRegs(8'hC3, 8'h0A, 8'h05, 8'h04);
    memWrite(8'h77);
  endtask : t_clip

  task automatic giveVerdict;
    if (nErrors == 0 && checkCount > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : giveVerdict

  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    giveVerdict();
  end

  initial begin
    {sysRst, memWr, maskedWriteEn, writeMode, rotateCount} = 8'h80;
    {cpuData, setReset, enableSetReset, bitMask} = 24'h00_00FF;
    {mapMask, maskedWriteMask, latchData} = 44'hFFF_0000_0000;
    repeat (3) @(negedge clk);
    sysRst = 1'b0;
    t_regs();
    t_walk();
    t_modes();
    t_clip();
    giveVerdict();
  end
endmodule : tb_color_expand_write_path

`default_nettype wire
